// File: dv/gpr_port_tb.sv
// Self-checking bench for the pin port register set
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module gpr_port_tb
    import gpr_pkg::*;
;
    logic core_clk, srst, clkEn, regWr, regRd;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata, pinIn, pinOut, pinOe, inputConnected;
    logic [11:0] offs [7] = '{12'h504, 12'h508, 12'h50C, 12'h510, 12'h514, 12'h518, 12'h51C};
    int errors = 0;
    int samplesChecked = 0;
    int cycleCount = 0;

    gpr_port dut_u (.core_clk(core_clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .inputConnected(inputConnected));

    // ****************************************
    // Bus, pin check and close-out tasks
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        `CHK("read data", e, regRdata)
    endtask : rd

    task automatic pins(input logic [31:0] lvl, input logic [31:0] dir);
        #1;
        `CHK("pin level", lvl, pinOut)
        `CHK("pin enable", dir, pinOe)
    endtask : pins

    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : closeOut

    // ****************************************
    // Clock and timeout
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycleCount++;
        if (cycleCount >= 1000) begin
            errors++;
            closeOut();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        srst = 1'b1;
        clkEn = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 12'h000;
        regWdata = 32'h0000_0000;
        pinIn = 32'hFFFF_FFFF;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(offs[i], 32'h0000_0000);
        `CHK("connected", 32'h0000_0000, inputConnected)
        $display("test reset done");
        wr(12'h504, 32'hA5A5_F00F);
        pins(32'hA5A5_F00F, 32'h0000_0000);
        wr(12'h508, 32'h0000_0FF0);
        pins(32'hA5A5_FFFF, 32'h0000_0000);
        wr(12'h50C, 32'hA000_000F);
        pins(32'h05A5_FFF0, 32'h0000_0000);
        for (int i = 0; i < 3; i++) rd(offs[i], 32'h05A5_FFF0);
        clkEn <= 1'b0;
        wr(12'h504, 32'hFFFF_FFFF);
        clkEn <= 1'b1;
        pins(32'h05A5_FFF0, 32'h0000_0000);
        $display("test level done");
        wr(12'h514, 32'h0000_FF00);
        pins(32'h05A5_FFF0, 32'h0000_FF00);
        wr(12'h518, 32'h8000_0001);
        wr(12'h51C, 32'h0000_0F00);
        pins(32'h05A5_FFF0, 32'h8000_F001);
        for (int i = 4; i < 7; i++) rd(offs[i], 32'h8000_F001);
        $display("test direction done");
        wr(12'h510, 32'hFFFF_FFFF);
        wr(12'h600, 32'hFFFF_FFFF);
        rd(12'h600, 32'h0000_0000);
        rd(12'h510, 32'h0000_0000);
        wr(12'h700, 32'h0000_0000);
        wr(12'h704, 32'h0000_0001);
        rd(12'h514, 32'h8000_F002);
        rd(12'h708, 32'h0000_0002);
        wr(12'h51C, 32'h0000_0002);
        rd(12'h704, 32'h0000_0000);
        `CHK("connected", 32'h0000_0003, inputConnected)
        @(posedge core_clk);
        pinIn <= 32'h0000_0005;
        repeat (4) @(posedge core_clk);
        rd(12'h510, 32'h0000_0001);
        $display("test sampled done");
        @(posedge core_clk);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        rd(12'h504, 32'h0000_0000);
        rd(12'h514, 32'h0000_0000);
        pins(32'h0000_0000, 32'h0000_0000);
        `CHK("connected", 32'h0000_0000, inputConnected)
        $display("test second reset done");
        closeOut();
    end
endmodule : gpr_port_tb

// File: rtl/gpr_pkg.sv
// Package with register map, field layout and reset values of the pin port
package gpr_pkg;
    localparam int GPR_PINS = 32;
    localparam int GPR_AW = 12;
    localparam logic [11:0] GPR_OFF_LEVEL = 12'h504;
    localparam logic [11:0] GPR_OFF_LEVEL_SET = 12'h508;
    localparam logic [11:0] GPR_OFF_LEVEL_CLR = 12'h50C;
    localparam logic [11:0] GPR_OFF_SAMPLED = 12'h510;
    localparam logic [11:0] GPR_OFF_DIR = 12'h514;
    localparam logic [11:0] GPR_OFF_DIR_SET = 12'h518;
    localparam logic [11:0] GPR_OFF_DIR_CLR = 12'h51C;
    localparam logic [11:0] GPR_OFF_CNF_BASE = 12'h700;
    localparam logic [11:0] GPR_OFF_CNF_LAST = 12'h77C;
    localparam int GPR_CNF_DIR_BIT = 0;
    localparam int GPR_CNF_INPUT_BIT = 1;
    localparam logic [31:0] GPR_RST_LEVEL = 32'h0000_0000;
    localparam logic [31:0] GPR_RST_DIR = 32'h0000_0000;
    localparam logic [31:0] GPR_RST_DISC = 32'hFFFF_FFFF;
    localparam logic [31:0] GPR_RST_SAMPLED = 32'h0000_0000;
    localparam logic [31:0] GPR_RD_UNMAPPED = 32'h0000_0000;
    localparam int GPR_SYNC_STAGES = 2;
endpackage : gpr_pkg

// File: rtl/gpr_port.sv
// Pin port register set: drive level, direction, sampled level, per-pin config
// Overview of operation
// - Drive-level register at 0x504, one bit per pin, resets to zero.
// - Set alias 0x508 raises written-one drive bits; reads give drive level.
// - Clear alias 0x50C lowers written-one drive bits; reads give drive level.
// - Read-only register 0x510 reports the sampled level of every connected pin; disconnected pins read zero.
// - Direction register at 0x514; one means output; resets to all inputs.
// - Direction-set alias 0x518 makes written-one pins outputs; reads give direction.
// - Direction-clear alias 0x51C makes written-one pins inputs; reads give direction.
// - Sampled level is valid only while that pin's input buffer is connected.
// - Per-pin config direction bit shares storage with the direction register.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module gpr_port
    import gpr_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [31:0] pinIn,
    output logic [31:0] pinOut,
    output logic [31:0] pinOe,
    output logic [31:0] inputConnected
);
    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic isCnf(input logic [11:0] a);
        isCnf = (a >= GPR_OFF_CNF_BASE) && (a <= GPR_OFF_CNF_LAST) && (a[1:0] == 2'h0);
    endfunction : isCnf

    logic [31:0] level_q;
    logic [31:0] level_d;
    logic [31:0] dir_q;
    logic [31:0] dir_d;
    logic [31:0] disc_q;
    logic [31:0] disc_d;
    logic [31:0] rdata_q;
    logic [31:0] pinOut_q;
    logic [31:0] pinOe_q;
    logic [31:0] conn_q;
    logic [31:0] sampled;
    logic [31:0] sampledValid;
    logic [31:0] cnfRead;
    logic [31:0] rdMux;
    logic [4:0] cnfIdx;

    wire hitLevel = regAddr == GPR_OFF_LEVEL;
    wire hitLevelSet = regAddr == GPR_OFF_LEVEL_SET;
    wire hitLevelClr = regAddr == GPR_OFF_LEVEL_CLR;
    wire hitSampled = regAddr == GPR_OFF_SAMPLED;
    wire hitDir = regAddr == GPR_OFF_DIR;
    wire hitDirSet = regAddr == GPR_OFF_DIR_SET;
    wire hitDirClr = regAddr == GPR_OFF_DIR_CLR;
    wire hitCnf = isCnf(regAddr);
    assign cnfIdx = regAddr[6:2];

    // ****************************************************************
    // Pin sampling
    // ****************************************************************
    gpr_sync uSync (
        .coreClk(core_clk),
        .srst(srst),
        .clkEn(clkEn),
        .asyncIn(pinIn),
        .syncOut(sampled)
    );

    assign sampledValid = sampled & ~disc_q;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    wire [31:0] cnfSel = 32'h0000_0001 << cnfIdx;
    wire cnfWr = regWr && hitCnf;

    assign level_d = (regWr && hitLevel) ? regWdata :
                     (regWr && hitLevelSet) ? (level_q | regWdata) :
                     (regWr && hitLevelClr) ? (level_q & ~regWdata) :
                     level_q;

    genvar gi;
    generate
        for (gi = 0; gi < GPR_PINS; gi++) begin : gPin
            assign dir_d[gi] = (regWr && hitDir) ? regWdata[gi] :
                               (regWr && hitDirSet && regWdata[gi]) ? 1'b1 :
                               (regWr && hitDirClr && regWdata[gi]) ? 1'b0 :
                               (cnfWr && cnfSel[gi]) ? regWdata[GPR_CNF_DIR_BIT] :
                               dir_q[gi];
            assign disc_d[gi] = (cnfWr && cnfSel[gi]) ? regWdata[GPR_CNF_INPUT_BIT] : disc_q[gi];
        end
    endgenerate

    // ****************************************************************
    // Read path
    // ****************************************************************
    assign cnfRead = {30'h0000_0000, disc_q[cnfIdx], dir_q[cnfIdx]};
    assign rdMux = (hitLevel || hitLevelSet || hitLevelClr) ? level_q :
                   hitSampled ? sampledValid :
                   (hitDir || hitDirSet || hitDirClr) ? dir_q :
                   hitCnf ? cnfRead :
                   GPR_RD_UNMAPPED;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            level_q <= GPR_RST_LEVEL;
            dir_q <= GPR_RST_DIR;
            disc_q <= GPR_RST_DISC;
            rdata_q <= GPR_RD_UNMAPPED;
            pinOut_q <= GPR_RST_LEVEL;
            pinOe_q <= GPR_RST_DIR;
            conn_q <= ~GPR_RST_DISC;
        end else if (clkEn) begin
            level_q <= level_d;
            dir_q <= dir_d;
            disc_q <= disc_d;
            rdata_q <= regRd ? rdMux : GPR_RD_UNMAPPED;
            pinOut_q <= level_d;
            pinOe_q <= dir_d;
            conn_q <= ~disc_d;
        end
    end

    assign regRdata = rdata_q;
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign inputConnected = conn_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_level_set: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regWr && hitLevelSet) |=> ((level_q & $past(regWdata)) == $past(regWdata)))
        else $error("set alias did not raise bits");
    chk_level_clr: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regWr && hitLevelClr) |=> ((level_q & $past(regWdata)) == 32'h0000_0000))
        else $error("clear alias did not lower bits");
    chk_level_write: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regWr && hitLevel) |=> (level_q == $past(regWdata)))
        else $error("drive level write lost");
    chk_pin_follow: assert property (@(posedge core_clk) disable iff (srst)
        (pinOut == level_q) && (pinOe == dir_q))
        else $error("pins differ from registers");
    chk_dir_set: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regWr && hitDirSet) |=> ((dir_q & $past(regWdata)) == $past(regWdata)))
        else $error("direction set failed");
    chk_dir_clr: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regWr && hitDirClr) |=> ((dir_q & $past(regWdata)) == 32'h0000_0000))
        else $error("direction clear failed");
    chk_dir_read: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regRd && hitDirSet) |=> (regRdata == $past(dir_q)))
        else $error("direction alias read wrong");
    chk_input_gate: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regRd && hitSampled) |=> ((regRdata & $past(disc_q)) == 32'h0000_0000))
        else $error("disconnected input reads high");
    chk_cnf_shared: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regRd && hitCnf) |=> (regRdata[0] == $past(dir_q[cnfIdx])))
        else $error("config direction bit mismatch");
    chk_alias_same: assert property (@(posedge core_clk) disable iff (srst)
        (clkEn && regWr && hitLevelSet) ##1 (clkEn && regRd && hitLevel) |=> (regRdata == $past(level_q)))
        else $error("alias write not visible");
endmodule : gpr_port

// File: rtl/gpr_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ns
module gpr_sync
    import gpr_pkg::*;
(
    input wire logic coreClk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [31:0] asyncIn,
    output logic [31:0] syncOut
);
    logic [31:0] meta_q;
    logic [31:0] sync_q;

    always_ff @(posedge coreClk) begin
        if (srst) begin
            meta_q <= GPR_RST_SAMPLED;
            sync_q <= GPR_RST_SAMPLED;
        end else if (clkEn) begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule : gpr_sync
